/* rtl/ssrx_pkg.sv */
/*
 * Shared constants and types for the synchronous serial receive and
 * transmit/receive block: register offsets, field layouts, reset values
 * and serial clock timing.
 * Assumes a 40 MHz system clock and an 8-bit register port.
 */
package ssrx_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [3:0] ADR_CTRL = 4'h0;
    localparam logic [3:0] ADR_STAT = 4'h1;
    localparam logic [3:0] ADR_RXB = 4'h2;
    localparam logic [3:0] ADR_TXB = 4'h3;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] BUF_RST = 8'h00;
    localparam logic TXE_RST = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // timing and counts
    localparam int SYS_CLK_NS = 25;
    localparam int SCK_HALF_NS = 100;
    localparam int SCK_HALF_CYC = (SCK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    ////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {MODE_TX, MODE_RX, MODE_TRX, MODE_RSV} ssrx_mode_t;

    // serial control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic transfer_start_bit;
        logic force_inhibit_bit;
        logic bit_order_sel;
        ssrx_mode_t transfer_mode_sel;
        logic ext_clk_sel;
        logic [1:0] rsv;
    } ssrx_ctrl_t;

    // one register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } ssrx_req_t;

endpackage : ssrx_pkg

/* rtl/ssrx_core.sv */
/*
 * Synchronous serial interface, receive-only and full-duplex modes, with
 * register port, internal or external serial clock, auto-wait, error flags.
 * Assumes: one sys_clk domain; serial pins asynchronous to it; external
 * serial clock half periods of several sys_clk cycles.
 */
// Decided for this implementation: the register addresses and the address-and-strobe port.
// What this block does
// - mode field 01 selects receive-only operation.
// - in-progress flag rises at the first falling serial clock after start.
// - input bits sampled on rising edges, order from bit-order select.
// - shift-active flag high from first to eighth falling edge of a byte.
// - after eight bits, copy to receive buffer, set full, raise interrupt.
// - internal clock starts toggling within one serial period of start.
// - reading the receive buffer clears the full flag.
// - internal clock parks high after a byte until buffer read, then resumes.
// - external clock, unread buffer at byte end sets receive error, interrupt.
// - clearing start finishes the byte, stops, then clears in-progress.
// - force-inhibit stops at once and reinitializes start, status, buffers.
// - while receive error is set, incoming bits are discarded.
// - after error, first read gives old byte, second gives captured byte.
// - recovery stops after eight more pulses; wait for in-progress zero.
// - no further interrupts while a receive error remains.
// - mode 10 is full duplex: drive on falling, capture on rising edges.
// - transmit-empty set on rising edge after load; interrupt with rx full.
// - external clock: first falling edge loads transmit byte immediately.
// - internal clock waits for rx read and tx write before next byte.
// - shift without new tx byte sets tx error, output high, irq at end.
// - stopping full duplex completes byte, clears in-progress, output high.
`timescale 1ns/1ps

module ssrx_core import ssrx_pkg::*; #(
    parameter int HALF_CYC = SCK_HALF_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // register port
    input wire ssrx_req_t req,
    output logic [7:0] rd_data,
    // serial pins
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic si_in,
    output logic so_out,
    // event
    output logic serial_irq
);

    if (HALF_CYC < 1 || HALF_CYC > 255) begin : g_bad_half
        $error("HALF_CYC must lie in 1..255");
    end

    ////////////////////////////////////////////////////////////////////////
    // state
    ssrx_ctrl_t serial_control_reg_r;
    logic transfer_in_progress_flag_r;
    logic shift_active_flag_r;
    logic rx_buffer_full_flag_r;
    logic tx_buffer_empty_flag_r;
    logic rx_error_flag_r;
    logic tx_error_flag_r;
    logic [7:0] rx_data_buffer_r;
    logic [7:0] tx_data_buffer_r;
    logic [7:0] rx_shift_r;
    logic [7:0] tx_shift_r;
    logic [3:0] fall_cnt_r;
    logic [3:0] rise_cnt_r;
    logic tx_load_pend_r;
    logic err_read_r;
    logic so_r;
    logic irq_r;
    logic [7:0] rd_data_r;
    logic sck_int_r;
    logic [7:0] div_r;
    logic sck_s1_r, sck_s2_r, si_s1_r, si_s2_r;
    logic sck_prev_r;
    logic recov_r;

    ////////////////////////////////////////////////////////////////////////
    // register decode
    wire ssrx_ctrl_t ctrl_w = ssrx_ctrl_t'(req.wdata);
    wire wr_ctrl = req.wr && req.addr == ADR_CTRL;
    wire wr_tx = req.wr && req.addr == ADR_TXB;
    wire rd_rx = req.rd && req.addr == ADR_RXB;
    wire inhibit = serial_control_reg_r.force_inhibit_bit;
    wire start = serial_control_reg_r.transfer_start_bit;
    wire dir_lsb = serial_control_reg_r.bit_order_sel;
    wire ext = serial_control_reg_r.ext_clk_sel;
    wire mode_rx = serial_control_reg_r.transfer_mode_sel == MODE_RX;
    wire mode_trx = serial_control_reg_r.transfer_mode_sel == MODE_TRX;
    wire mode_ok = mode_rx || mode_trx;
    wire [7:0] stat_w = {transfer_in_progress_flag_r, shift_active_flag_r, rx_buffer_full_flag_r,
                         tx_buffer_empty_flag_r, rx_error_flag_r, tx_error_flag_r, 2'b00};
    wire [7:0] rd_mux = (req.addr == ADR_CTRL) ? serial_control_reg_r :
                        (req.addr == ADR_STAT) ? stat_w :
                        (req.addr == ADR_RXB) ? rx_data_buffer_r :
                        (req.addr == ADR_TXB) ? tx_data_buffer_r : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // serial clock edges
    wire sck_lvl = ext ? sck_s2_r : sck_int_r;
    wire fall = sck_prev_r && !sck_lvl;
    wire rise = !sck_prev_r && sck_lvl;
    wire in_byte = fall_cnt_r != 4'h0;
    // start cleared during an error arms one more byte; eight more pulses end it
    wire recov_set = start && wr_ctrl && !ctrl_w.transfer_start_bit && rx_error_flag_r;
    // a flag, not the error itself, so error reads cannot cut the recovery short
    wire go = start || recov_r;
    // buffers must be serviced before an internally clocked byte starts
    wire ready_int = !rx_buffer_full_flag_r && (!mode_trx || !tx_buffer_empty_flag_r);
    wire gen_start = !ext && go && mode_ok && ready_int && !inhibit;
    wire gen_run = !ext && !inhibit && (in_byte || gen_start);
    wire div_end = div_r == 8'(HALF_CYC - 1);
    wire begin_ev = fall && !in_byte && mode_ok && go && !inhibit;
    wire shift_ev = fall && in_byte && fall_cnt_r < BYTE_BITS;
    wire samp_ev = rise && in_byte && !inhibit;
    wire byte_done = samp_ev && rise_cnt_r == BYTE_BITS - 4'h1;

    ////////////////////////////////////////////////////////////////////////
    // receive path
    wire [7:0] rx_shifted = dir_lsb ? {si_s2_r, rx_shift_r[7:1]} : {rx_shift_r[6:0], si_s2_r};
    wire rx_room = !rx_buffer_full_flag_r || rd_rx;
    wire rx_ok_done = byte_done && !rx_error_flag_r && (rx_room || !ext);
    wire rx_err_set = byte_done && !rx_error_flag_r && !rx_room && ext;
    wire err_read1 = rd_rx && rx_error_flag_r && !err_read_r;
    wire err_read2 = rd_rx && rx_error_flag_r && err_read_r;

    ////////////////////////////////////////////////////////////////////////
    // transmit path
    wire tx_err_now = begin_ev && mode_trx && tx_buffer_empty_flag_r && ext;
    wire tx_load = begin_ev && mode_trx && !tx_err_now;
    wire [7:0] tx_next = dir_lsb ? {1'b1, tx_shift_r[7:1]} : {tx_shift_r[6:0], 1'b1};
    wire tx_first = dir_lsb ? tx_data_buffer_r[0] : tx_data_buffer_r[7];
    wire tx_bit = dir_lsb ? tx_next[0] : tx_next[7];

    ////////////////////////////////////////////////////////////////////////
    // next values
    ssrx_ctrl_t ctrl_nxt;
    always_comb begin
        ctrl_nxt = serial_control_reg_r;
        if (wr_ctrl) begin
            ctrl_nxt = ctrl_w;
            ctrl_nxt.rsv = 2'b00;
        end
        if (inhibit) begin
            ctrl_nxt.transfer_start_bit = 1'b0;
        end
    end

    wire act_nxt = inhibit ? 1'b0 :
                   begin_ev ? 1'b1 :
                   (!in_byte && !go) ? 1'b0 :
                   transfer_in_progress_flag_r;
    wire sef_nxt = (inhibit || (fall && fall_cnt_r == BYTE_BITS - 4'h1)) ? 1'b0 :
                   begin_ev ? 1'b1 : shift_active_flag_r;
    // a byte landing in the same cycle as a read keeps the flag set
    wire rxf_nxt = inhibit ? 1'b0 :
                   rx_ok_done ? 1'b1 :
                   err_read2 ? 1'b0 :
                   (rd_rx && !rx_error_flag_r) ? 1'b0 :
                   rx_buffer_full_flag_r;
    wire rxe_nxt = inhibit ? 1'b0 : rx_err_set ? 1'b1 : err_read2 ? 1'b0 : rx_error_flag_r;
    wire txe_set = rise && tx_load_pend_r;
    wire txe_nxt = inhibit ? TXE_RST : txe_set ? 1'b1 : wr_tx ? 1'b0 : tx_buffer_empty_flag_r;
    wire txe_err_nxt = inhibit ? 1'b0 : tx_err_now ? 1'b1 : tx_error_flag_r;
    wire [7:0] rxb_nxt = inhibit ? BUF_RST :
                         rx_ok_done ? rx_shifted :
                         err_read1 ? rx_shift_r :
                         rx_data_buffer_r;
    wire [7:0] rsh_nxt = inhibit ? BUF_RST : (samp_ev && !rx_error_flag_r) ? rx_shifted : rx_shift_r;
    wire [7:0] txb_nxt = inhibit ? BUF_RST : wr_tx ? req.wdata : tx_data_buffer_r;
    wire [7:0] tsh_nxt = inhibit ? 8'hff : tx_load ? tx_data_buffer_r : shift_ev ? tx_next : tx_shift_r;
    wire so_nxt = inhibit ? 1'b1 :
                  tx_load ? tx_first :
                  (!mode_trx || tx_error_flag_r || tx_err_now) ? 1'b1 :
                  (shift_ev && transfer_in_progress_flag_r) ? tx_bit :
                  !transfer_in_progress_flag_r ? 1'b1 : so_r;
    wire [3:0] fcnt_nxt = (inhibit || byte_done) ? 4'h0 :
                          begin_ev ? 4'h1 : shift_ev ? fall_cnt_r + 4'h1 : fall_cnt_r;
    wire [3:0] rcnt_nxt = (inhibit || byte_done) ? 4'h0 : samp_ev ? rise_cnt_r + 4'h1 : rise_cnt_r;
    wire pend_nxt = inhibit ? 1'b0 : tx_load ? 1'b1 : txe_set ? 1'b0 : tx_load_pend_r;
    wire errrd_nxt = (inhibit || err_read2) ? 1'b0 : err_read1 ? 1'b1 : err_read_r;
    // recovery ends with the byte it waits for and is never re-armed by a standing error
    wire recov_nxt = (inhibit || byte_done) ? 1'b0 : recov_set ? 1'b1 : recov_r;
    // one request per byte, none while an earlier error stands
    wire irq_nxt = byte_done && !rx_error_flag_r;
    wire sck_nxt = !gen_run ? 1'b1 : div_end ? !sck_int_r : sck_int_r;
    wire [7:0] div_nxt = (!gen_run || div_end) ? 8'h00 : div_r + 8'h01;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            {sck_s1_r, sck_s2_r, si_s1_r, si_s2_r, sck_prev_r} <= 5'h1f;
        end else begin
            {sck_s1_r, sck_s2_r} <= {sck_in, sck_s1_r};
            {si_s1_r, si_s2_r} <= {si_in, si_s1_r};
            sck_prev_r <= sck_lvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control, status and buffers
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            serial_control_reg_r <= ssrx_ctrl_t'(CTRL_RST);
            transfer_in_progress_flag_r <= 1'b0;
            shift_active_flag_r <= 1'b0;
            rx_buffer_full_flag_r <= 1'b0;
            tx_buffer_empty_flag_r <= TXE_RST;
            rx_error_flag_r <= 1'b0;
            tx_error_flag_r <= 1'b0;
            rx_data_buffer_r <= BUF_RST;
            tx_data_buffer_r <= BUF_RST;
        end else begin
            serial_control_reg_r <= ctrl_nxt;
            transfer_in_progress_flag_r <= act_nxt;
            shift_active_flag_r <= sef_nxt;
            rx_buffer_full_flag_r <= rxf_nxt;
            tx_buffer_empty_flag_r <= txe_nxt;
            rx_error_flag_r <= rxe_nxt;
            tx_error_flag_r <= txe_err_nxt;
            rx_data_buffer_r <= rxb_nxt;
            tx_data_buffer_r <= txb_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shifters, counters, clock generator, outputs
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rx_shift_r <= BUF_RST;
            tx_shift_r <= 8'hff;
            fall_cnt_r <= 4'h0;
            rise_cnt_r <= 4'h0;
            tx_load_pend_r <= 1'b0;
            err_read_r <= 1'b0;
            recov_r <= 1'b0;
            so_r <= 1'b1;
            irq_r <= 1'b0;
            sck_int_r <= 1'b1;
            div_r <= 8'h00;
            rd_data_r <= 8'h00;
        end else begin
            rx_shift_r <= rsh_nxt;
            tx_shift_r <= tsh_nxt;
            fall_cnt_r <= fcnt_nxt;
            rise_cnt_r <= rcnt_nxt;
            tx_load_pend_r <= pend_nxt;
            err_read_r <= errrd_nxt;
            recov_r <= recov_nxt;
            so_r <= so_nxt;
            irq_r <= irq_nxt;
            sck_int_r <= sck_nxt;
            div_r <= div_nxt;
            rd_data_r <= req.rd ? rd_mux : 8'h00;
        end
    end

    assign rd_data = rd_data_r;
    assign sck_out = sck_int_r;
    assign sck_oe = !ext && mode_ok;
    assign so_out = so_r;
    assign serial_irq = irq_r;

    ////////////////////////////////////////////////////////////////////////
    // checks
    localparam int AST_WIN = 2 * HALF_CYC + 2;
    default clocking ck @(posedge sys_clk); endclocking
    default disable iff (reset);

    AST_ACTIVE_ON_FALL: assert property (
        $rose(transfer_in_progress_flag_r) |-> $past(fall) && shift_active_flag_r && fall_cnt_r == 4'h1)
        else $error("in-progress rose without a falling serial edge");

    AST_SEF_ENDS_AT_EIGHTH: assert property (
        $fell(shift_active_flag_r) && !$past(inhibit) |-> $past(fall) && fall_cnt_r == BYTE_BITS)
        else $error("shift-active fell away from the eighth falling edge");

    AST_RX_BYTE_STORED: assert property (
        rx_ok_done |=> rx_buffer_full_flag_r && serial_irq && rx_data_buffer_r == $past(rx_shifted))
        else $error("completed byte not stored with flag and interrupt");

    AST_READ_CLEARS_FULL: assert property (
        rd_rx && !rx_error_flag_r && !byte_done |=> !rx_buffer_full_flag_r)
        else $error("receive buffer read left full flag set");

    AST_CLOCK_STARTS: assert property (
        $rose(gen_start) |-> ##[1:AST_WIN] (in_byte || !gen_start))
        else $error("internal serial clock did not start in time");

    AST_PARK_HIGH: assert property (
        !ext && !in_byte && !$past(in_byte) && rx_buffer_full_flag_r |-> sck_out && $stable(sck_out))
        else $error("internal clock not parked high while buffer full");

    AST_RX_ERROR: assert property (
        rx_err_set |=> rx_error_flag_r && serial_irq && rx_data_buffer_r == $past(rx_data_buffer_r))
        else $error("overrun did not raise error and interrupt");

    AST_ERR_DISCARD: assert property (
        rx_error_flag_r && $past(rx_error_flag_r) |-> $stable(rx_shift_r))
        else $error("shift register changed during receive error");

    AST_NO_IRQ_IN_ERR: assert property (
        rx_error_flag_r && $past(rx_error_flag_r) |-> !serial_irq)
        else $error("interrupt raised during receive error");

    AST_INHIBIT_CLEARS: assert property (
        inhibit |=> !transfer_in_progress_flag_r && !start && !rx_buffer_full_flag_r &&
                    rx_data_buffer_r == BUF_RST && tx_data_buffer_r == BUF_RST)
        else $error("force-inhibit did not reinitialize");

    AST_TXE_ON_RISE: assert property (
        $rose(tx_buffer_empty_flag_r) && !$past(inhibit) |-> $past(rise) && !tx_load_pend_r)
        else $error("transmit-empty set away from a rising edge after load");

    AST_TX_ERROR_FLAG_SO_HIGH: assert property (
        tx_error_flag_r ##1 tx_error_flag_r |-> so_out)
        else $error("serial output not high during transmit error");

    AST_IDLE_SO_HIGH: assert property (
        !transfer_in_progress_flag_r [*2] |-> so_out)
        else $error("serial output not high while stopped");

    AST_STOP_AFTER_BYTE: assert property (
        $fell(transfer_in_progress_flag_r) && !$past(inhibit) |-> !$past(in_byte) && !$past(go))
        else $error("in-progress cleared inside a byte or while still started");

    AST_ERR_READ_COPY: assert property (
        err_read1 && !inhibit |=> rx_data_buffer_r == $past(rx_shift_r) && rx_error_flag_r)
        else $error("first error read did not copy the captured byte");

    AST_RECOVERY_HOLDS: assert property (
        recov_r && !in_byte |-> transfer_in_progress_flag_r)
        else $error("in-progress dropped before the recovery byte");

    AST_TX_LOAD: assert property (
        tx_load |=> tx_shift_r == $past(tx_data_buffer_r) && so_out == $past(tx_first))
        else $error("transmit byte not loaded at the first falling edge");

    AST_TRX_WAIT: assert property (
        !ext && mode_trx && tx_buffer_empty_flag_r && !in_byte && !$past(in_byte) |-> sck_out)
        else $error("internal clock ran without a new transmit byte");

    // recovery is the only path that starts a byte after the start bit is gone
    COV_RECOVERY: cover property (recov_r && byte_done);
    COV_RX_BYTE: cover property (rx_ok_done && mode_rx);
    COV_TRX_BYTE: cover property (rx_ok_done && mode_trx);
    COV_RX_ERR: cover property (rx_err_set);
    COV_TX_ERR: cover property (tx_err_now);
    COV_ERR_READS: cover property (err_read1 ##[1:40] err_read2);

endmodule : ssrx_core

/* test/ssrx_peer.sv */
/*
 * Serial peer model: shifts a byte out on si, collects so, and makes the
 * external serial clock on demand.
 * Assumes the bench feeds the wire level of the serial clock back in.
 */
`timescale 1ns/1ps

module ssrx_peer (
    // link
    input wire logic sck,
    input wire logic so,
    output logic si,
    output logic sck_ext,
    // bit order, 1 for lsb first
    input wire logic lsb
);
    logic [7:0] tx_r;
    logic [7:0] rx_r;
    int cnt;

    initial begin
        si = 1'h1;
        sck_ext = 1'h1;
        tx_r = 8'h00;
        rx_r = 8'h00;
        cnt = 0;
    end

    ////////////////////////////////////////////////////////////////////////
    // data changes on falls and is captured on rises
    always @(negedge sck) begin
        si <= lsb ? tx_r[cnt] : tx_r[7 - cnt];
        cnt <= (cnt + 1) % 8;
    end

    always @(posedge sck) begin
        rx_r <= lsb ? {so, rx_r[7:1]} : {rx_r[6:0], so};
    end

    task automatic load(input logic [7:0] b);
        tx_r = b;
        cnt = 0;
    endtask : load

    // clock stands high between frames; 100 ns halves meet the minimum width
    task automatic pulses(input int n);
        repeat (n) begin
            sck_ext = 1'h0;
            #100;
            sck_ext = 1'h1;
            #100;
        end
    endtask : pulses
endmodule : ssrx_peer

/* test/test_sync_serial_rx_trx_modes.sv */
/*
 * Self-checking bench for ssrx_core: register port tasks, receive and
 * full-duplex runs on internal and external clock, error recovery.
 * Assumes the peer model ssrx_peer and a 40 MHz system clock.
 */
`timescale 1ns/1ps

module test_sync_serial_rx_trx_modes import ssrx_pkg::*;;
    logic sys_clk;
    logic reset;
    ssrx_req_t req;
    logic [7:0] rd_data;
    logic sck_out, sck_oe, so_out, serial_irq, sck_ext, si, lsb, sck_pin;
    logic [7:0] d;
    int failures = 0;
    int check_count = 0;
    int irq_cnt = 0;
    int cyc = 0;
    int base;

    assign sck_pin = sck_oe ? sck_out : sck_ext;

    ssrx_core #(.HALF_CYC(4)) dut_u (
        .sys_clk(sys_clk), .reset(reset), .req(req), .rd_data(rd_data),
        .sck_in(sck_pin), .sck_out(sck_out), .sck_oe(sck_oe), .si_in(si),
        .so_out(so_out), .serial_irq(serial_irq)
    );
    ssrx_peer peer_u (.sck(sck_pin), .so(so_out), .si(si), .sck_ext(sck_ext), .lsb(lsb));

    initial begin
        sys_clk = 1'h0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (serial_irq === 1'h1) irq_cnt <= irq_cnt + 1;
        if (cyc == 20000) begin
            failures++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        req <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: v};
        @(posedge sys_clk);
        req <= '0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        req <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
        @(posedge sys_clk);
        req <= '0;
        #1 v = rd_data;
    endtask : rd

    task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk(v, exp);
    endtask : rdc

    task automatic wait_stat(input logic [7:0] m);
        logic [7:0] s;
        for (int i = 0; i < 400; i++) begin
            rd(ADR_STAT, s);
            if ((s & m) === m) break;
        end
        chk(s & m, m);
    endtask : wait_stat

    task automatic rx_int(input logic ord, input logic [7:0] b);
        lsb = ord;
        peer_u.load(b);
        wr(ADR_CTRL, {1'h1, 1'h0, ord, MODE_RX, 3'h0});
        repeat (10) @(posedge sys_clk);
        rdc(ADR_STAT, 8'hd0);
        wait_stat(8'h20);
        repeat (20) @(posedge sys_clk);
        chk({7'h00, sck_out}, 8'h01);
        wr(ADR_CTRL, {1'h0, 1'h0, ord, MODE_RX, 3'h0});
        rdc(ADR_STAT, 8'h30);
        rdc(ADR_RXB, b);
        rdc(ADR_STAT, 8'h10);
    endtask : rx_int

    ////////////////////////////////////////////////////////////////////////
    initial begin
        reset = 1'h1;
        req = '0;
        lsb = 1'h0;
        repeat (8) @(posedge sys_clk);
        reset <= 1'h0;
        rdc(ADR_STAT, TXE_RST ? 8'h10 : 8'h00);
        rdc(ADR_CTRL, CTRL_RST);
        rdc(ADR_RXB, BUF_RST);
        wr(4'h9, 8'hff);
        rdc(4'h9, 8'h00);
        rdc(ADR_CTRL, CTRL_RST);
        // internal clock receive, both bit orders
        rx_int(1'h0, 8'ha5);
        rx_int(1'h1, 8'h3c);
        chk(irq_cnt[7:0], 8'h02);
        // internal clock full duplex
        lsb = 1'h0;
        peer_u.load(8'hc3);
        wr(ADR_TXB, 8'h5a);
        rdc(ADR_STAT, 8'h00);
        wr(ADR_CTRL, {1'h1, 1'h0, 1'h0, MODE_TRX, 3'h0});
        wait_stat(8'h30);
        chk(irq_cnt[7:0], 8'h03);
        rdc(ADR_RXB, 8'hc3);
        repeat (24) @(posedge sys_clk);
        chk({7'h00, sck_out}, 8'h01);
        wr(ADR_CTRL, {1'h0, 1'h0, 1'h0, MODE_TRX, 3'h0});
        chk(peer_u.rx_r, 8'h5a);
        // in-progress clears a cycle after the stop lands, the output a cycle later
        repeat (3) @(posedge sys_clk);
        chk({7'h00, so_out}, 8'h01);
        rdc(ADR_STAT, 8'h10);
        // external clock receive overrun and recovery
        wr(ADR_CTRL, {1'h1, 1'h0, 1'h0, MODE_RX, 3'h4});
        peer_u.load(8'h11);
        peer_u.pulses(8);
        peer_u.load(8'h22);
        peer_u.pulses(8);
        repeat (8) @(posedge sys_clk);
        rd(ADR_STAT, d);
        chk(d & 8'h3c, 8'h38);
        chk(irq_cnt[7:0], 8'h05);
        peer_u.load(8'h33);
        peer_u.pulses(8);
        repeat (8) @(posedge sys_clk);
        chk(irq_cnt[7:0], 8'h05);
        wr(ADR_CTRL, {1'h0, 1'h0, 1'h0, MODE_RX, 3'h4});
        rdc(ADR_RXB, 8'h11);
        rdc(ADR_RXB, 8'h22);
        rd(ADR_STAT, d);
        chk(d & 8'h80, 8'h80);
        peer_u.pulses(8);
        repeat (8) @(posedge sys_clk);
        rd(ADR_STAT, d);
        chk(d & 8'h80, 8'h00);
        // external clock full duplex with no transmit byte written
        wr(ADR_CTRL, 8'h40);
        wr(ADR_CTRL, 8'h00);
        base = irq_cnt;
        wr(ADR_CTRL, {1'h1, 1'h0, 1'h0, MODE_TRX, 3'h4});
        peer_u.load(8'h77);
        peer_u.pulses(8);
        repeat (8) @(posedge sys_clk);
        rd(ADR_STAT, d);
        chk(d & 8'h3c, 8'h34);
        chk(peer_u.rx_r, 8'hff);
        chk(8'(irq_cnt - base), 8'h01);
        rdc(ADR_RXB, 8'h77);
        wr(ADR_CTRL, {1'h1, 1'h1, 1'h0, MODE_TRX, 3'h4});
        rdc(ADR_STAT, 8'h10);
        rdc(ADR_CTRL, {1'h0, 1'h1, 1'h0, MODE_TRX, 3'h4});
        rdc(ADR_RXB, 8'h00);
        results();
    end
endmodule : test_sync_serial_rx_trx_modes
